/* File: core/sebw_slave.sv */
// Two-wire bus slave front end with page write buffer and write cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sebw_map.svh"
module sebw_slave #(
  parameter int          WC_CYCLES = `SEBW_WC_CYCLES,
  parameter logic [3:0]  DEV_CODE  = 4'hC  // Arbitrary value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  input  wire logic        i_wp,
  input  wire logic        i_chip_select_high_pin,
  input  wire logic        i_chip_select_low_pin,
  output logic             o_arr_re,
  output logic             o_arr_we,
  output logic [16:0]      o_arr_addr,
  output logic [7:0]       o_arr_wdata,
  input  wire logic [7:0]  i_arr_rdata,
  output logic             o_busy
);
  import sebw_pkg::*;

  sebw_state_t r;
  sebw_state_t n;
  sebw_pb_if   pb ();

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ctrl_hit;
  logic byte_end;
  logic wd_store;

  // =====================================================================
  // Pin sampling and bus conditions
  // =====================================================================
  assign scl_s     = r.s[4];
  assign sda_s     = r.s[3];
  assign wp_s      = r.s[2];
  assign scl_rise  = scl_s & ~r.scl_p;
  assign scl_fall  = ~scl_s & r.scl_p;
  assign start_det = scl_s & r.scl_p & r.sda_p & ~sda_s;
  assign stop_det  = scl_s & r.scl_p & ~r.sda_p & sda_s;
  assign byte_end  = scl_fall & ~r.ack & (r.cnt == `SEBW_BYTE_BITS);
  assign ctrl_hit  = (r.sh[`SEBW_CODE_MSB:`SEBW_CODE_LSB] == DEV_CODE)
                   & (r.sh[`SEBW_CSH_POS] == r.s[1])
                   & (r.sh[`SEBW_CSL_POS] == r.s[0]);
  assign wd_store  = byte_end & (r.st == SEBW_S_WD);

  // =====================================================================
  // Page buffer
  // =====================================================================
  assign pb.wr_en   = wd_store;
  assign pb.wr_addr = r.ptr[6:0];
  assign pb.wr_data = r.sh;
  assign pb.rd_addr = r.idx;

  sebw_page_buf u_buf (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .pb       (pb)
  );

  // =====================================================================
  // Next state
  // =====================================================================
  always_comb begin
    n = r;
    n.m = {i_scl, i_sda, i_wp, i_chip_select_high_pin, i_chip_select_low_pin};
    n.s = r.m;
    n.scl_p = r.s[4];
    n.sda_p = r.s[3];
    n.arr_re = 1'b0;
    n.arr_we = 1'b0;
    n.rd_pend = r.arr_re & ~r.busy;
    if (r.rd_pend) begin
      n.rbuf = i_arr_rdata;
    end

    // Self-timed write cycle: sweep the page first, then run out the time.
    if (r.busy) begin
      n.wc = r.wc + 17'h00001;
      if (r.wc == 17'(WC_CYCLES - 1)) begin
        n.busy = 1'b0;
      end
      if (r.sweep) begin
        case (r.step)
          2'h0: begin
            n.arr_re   = 1'b1;
            n.arr_addr = {r.pg, r.idx};
            n.step     = 2'h1;
          end
          2'h1: begin
            n.step = 2'h2;
          end
          2'h2: begin
            // Untouched bytes are rewritten with what the array held.
            n.arr_we    = 1'b1;
            n.arr_wdata = r.valid[r.idx] ? pb.rd_data : i_arr_rdata;
            n.step      = 2'h0;
            n.idx       = r.idx + 7'h01;
            if (r.idx == `SEBW_PAGE_LAST) begin
              n.sweep = 1'b0;
            end
          end
          default: begin
            n.step = 2'h0;
          end
        endcase
      end
    end

    if (start_det) begin
      n.st     = SEBW_S_CTRL;
      n.cnt    = 4'h0;
      n.ack    = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_det) begin
      if ((r.st == SEBW_S_WD) && r.wrote) begin
        if (!wp_s) begin
          n.busy  = 1'b1;
          n.wc    = 17'h00000;
          n.sweep = 1'b1;
          n.step  = 2'h0;
          n.idx   = 7'h00;
          n.pg    = r.ptr[16:7];
        end else begin
          n.valid = '0;
        end
      end
      n.st     = SEBW_S_IDLE;
      n.ack    = 1'b0;
      n.sda_oe = 1'b0;
      n.wrote  = 1'b0;
    end else if (r.st != SEBW_S_IDLE) begin
      if (scl_rise) begin
        if (r.st == SEBW_S_RD) begin
          if (r.ack) begin
            n.mack = ~sda_s;
          end else begin
            n.cnt = r.cnt + 4'h1;
          end
        end else if (!r.ack && (r.cnt != `SEBW_BYTE_BITS)) begin
          n.sh  = {r.sh[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (r.st == SEBW_S_RD) begin
          if (r.ack) begin
            if (r.mack) begin
              n.ack    = 1'b0;
              n.cnt    = 4'h0;
              n.sh     = r.rbuf;
              n.sda_oe = ~r.rbuf[7];
            end else begin
              n.st     = SEBW_S_IDLE;
              n.ack    = 1'b0;
              n.sda_oe = 1'b0;
            end
          end else if (r.cnt == `SEBW_BYTE_BITS) begin
            // Release for the master's bit and fetch the next byte early.
            n.ack      = 1'b1;
            n.sda_oe   = 1'b0;
            n.ptr      = {r.ptr[16], r.ptr[15:0] + 16'h0001};
            n.arr_re   = 1'b1;
            n.arr_addr = {r.ptr[16], r.ptr[15:0] + 16'h0001};
          end else begin
            n.sh     = {r.sh[6:0], 1'b0};
            n.sda_oe = ~r.sh[6];
          end
        end else if (r.ack) begin
          n.ack    = 1'b0;
          n.sda_oe = 1'b0;
          n.cnt    = 4'h0;
        end else if (r.cnt == `SEBW_BYTE_BITS) begin
          n.ack    = 1'b1;
          n.sda_oe = 1'b1;
          case (r.st)
            SEBW_S_CTRL: begin
              if (!ctrl_hit || r.busy) begin
                n.st     = SEBW_S_IDLE;
                n.ack    = 1'b0;
                n.sda_oe = 1'b0;
              end else begin
                n.ptr[16] = r.sh[`SEBW_BLK_POS];
                if (r.sh[`SEBW_RW_POS]) begin
                  n.st       = SEBW_S_RD;
                  n.arr_re   = 1'b1;
                  n.arr_addr = {r.sh[`SEBW_BLK_POS], r.ptr[15:0]};
                end else begin
                  n.st    = SEBW_S_AH;
                  n.valid = '0;
                  n.wrote = 1'b0;
                end
              end
            end
            SEBW_S_AH: begin
              n.ptr[15:8] = r.sh;
              n.st        = SEBW_S_AL;
            end
            SEBW_S_AL: begin
              n.ptr[7:0] = r.sh;
              n.st       = SEBW_S_WD;
            end
            SEBW_S_WD: begin
              n.valid[r.ptr[6:0]] = 1'b1;
              n.wrote             = 1'b1;
              n.ptr[6:0]          = r.ptr[6:0] + 7'h01;
            end
            default: begin
              n.st     = SEBW_S_IDLE;
              n.ack    = 1'b0;
              n.sda_oe = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r        <= '0;
      r.st     <= SEBW_S_IDLE;
      r.sda_oe <= `SEBW_OE_RST;
      r.ptr    <= `SEBW_PTR_RST;
      r.m      <= 5'h1F;
      r.s      <= 5'h1F;
      r.scl_p  <= 1'b1;
      r.sda_p  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // =====================================================================
  // Outputs
  // =====================================================================
  // The pin is open drain: only the enable moves, the driven level is low.
  assign o_sda       = 1'b0;
  assign o_sda_oe    = r.sda_oe;
  assign o_arr_re    = r.arr_re;
  assign o_arr_we    = r.arr_we;
  assign o_arr_addr  = r.arr_addr;
  assign o_arr_wdata = r.arr_wdata;
  assign o_busy      = r.busy;

  // =====================================================================
  // Checks
  // =====================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_start_frames: assert property (start_det |=> (r.st == SEBW_S_CTRL) && (r.cnt == 4'h0))
    else $error("start did not open a control byte");
  a_stop_idles: assert property (stop_det |=> (r.st == SEBW_S_IDLE) && !r.sda_oe)
    else $error("stop did not release the bus");
  a_drive_low_only: assert property (($changed(r.sda_oe) && !$past(start_det || stop_det))
      |-> !$past(scl_s))
    else $error("data drive changed while clock high");
  a_ack_holds: assert property ((r.ack && (r.st != SEBW_S_RD) && scl_s) |-> r.sda_oe)
    else $error("acknowledge not held low during clock high");
  a_ctrl_reject: assert property ((byte_end && (r.st == SEBW_S_CTRL) && (!ctrl_hit || r.busy))
      |=> ((r.st == SEBW_S_IDLE) && !r.sda_oe) [*2])
    else $error("control byte acknowledged while busy or mismatched");
  a_write_accept: assert property ((byte_end && (r.st == SEBW_S_CTRL) && ctrl_hit && !r.busy
      && !r.sh[0]) |=> (r.st == SEBW_S_AH) && r.sda_oe && (r.ptr[16] == $past(r.sh[1])))
    else $error("write control byte not decoded");
  a_read_nack: assert property ((scl_fall && (r.st == SEBW_S_RD) && r.ack && !r.mack)
      |=> (r.st == SEBW_S_IDLE) && !r.sda_oe)
    else $error("read not ended on master no-acknowledge");
  a_page_wrap: assert property (wd_store |=> (r.ptr[16:7] == $past(r.ptr[16:7]))
      && (r.ptr[6:0] == $past(r.ptr[6:0]) + 7'h01))
    else $error("page pointer did not wrap in page");
  a_read_block: assert property ((byte_end && (r.st == SEBW_S_RD))
      |=> r.ptr[16] == $past(r.ptr[16]))
    else $error("sequential read crossed its block");
  a_stop_cycle: assert property ((stop_det && (r.st == SEBW_S_WD) && r.wrote && !wp_s)
      |=> r.busy && (r.wc == 17'h00000))
    else $error("stop did not start the write cycle");
  a_wp_skip: assert property ((stop_det && (r.st == SEBW_S_WD) && r.wrote && wp_s)
      |=> !r.busy && (r.valid == '0))
    else $error("protected write started a cycle");
  a_cycle_len: assert property ($fell(r.busy) |-> $past(r.wc) == 17'(WC_CYCLES - 1))
    else $error("write cycle length wrong");
  a_merge_page: assert property (r.arr_we |-> r.busy && (r.arr_addr[16:7] == r.pg))
    else $error("page program left its page");

endmodule // sebw_slave
`default_nettype wire

/* File: pkg/sebw_map.svh */
// Constants for the serial memory bus write slave.
`ifndef SEBW_MAP_SVH
`define SEBW_MAP_SVH

`define SEBW_CLK_HZ       20000000
`define SEBW_WC_MS        5
`define SEBW_WC_CYCLES    (`SEBW_WC_MS * (`SEBW_CLK_HZ / 1000))
`define SEBW_BYTE_BITS    4'h8
`define SEBW_PAGE_LAST    7'h7F
`define SEBW_CODE_MSB     7
`define SEBW_CODE_LSB     4
`define SEBW_CSH_POS      3
`define SEBW_CSL_POS      2
`define SEBW_BLK_POS      1
`define SEBW_RW_POS       0
`define SEBW_OE_RST       1'b0
`define SEBW_PTR_RST      17'h00000

`endif

/* File: pkg/sebw_pkg.sv */
// Types shared by the serial memory bus write slave.
`default_nettype none
package sebw_pkg;

  typedef enum logic [2:0] {
    SEBW_S_IDLE = 3'b000,
    SEBW_S_CTRL = 3'b001,
    SEBW_S_AH   = 3'b010,
    SEBW_S_AL   = 3'b011,
    SEBW_S_WD   = 3'b100,
    SEBW_S_RD   = 3'b101
  } sebw_st_t;

  typedef struct packed {
    sebw_st_t      st;
    logic [3:0]    cnt;
    logic          ack;
    logic          mack;
    logic [7:0]    sh;
    logic          sda_oe;
    logic [16:0]   ptr;
    logic          wrote;
    logic [127:0]  valid;
    logic          busy;
    logic [16:0]   wc;
    logic          sweep;
    logic [1:0]    step;
    logic [6:0]    idx;
    logic [9:0]    pg;
    logic          arr_re;
    logic          arr_we;
    logic [16:0]   arr_addr;
    logic [7:0]    arr_wdata;
    logic [7:0]    rbuf;
    logic          rd_pend;
    logic [4:0]    m;
    logic [4:0]    s;
    logic          scl_p;
    logic          sda_p;
  } sebw_state_t;

  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0]        rd_data;
  } sebw_buf_t;

endpackage
`default_nettype wire

/* File: pkg/sebw_pb_if.sv */
// Page buffer port between the bus slave and its buffer memory.
`timescale 1ns/1ps
`default_nettype none
interface sebw_pb_if;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: core/sebw_page_buf.sv */
// 128-byte page buffer with registered read data.
`timescale 1ns/1ps
`default_nettype none
module sebw_page_buf (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  sebw_pb_if.mem    pb
);
  import sebw_pkg::*;

  sebw_buf_t r;
  sebw_buf_t n;

  always_comb begin
    n = r;
    n.rd_data = r.mem[pb.rd_addr];
    if (pb.wr_en) begin
      n.mem[pb.wr_addr] = pb.wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pb.rd_data = r.rd_data;
endmodule // sebw_page_buf
`default_nettype wire

/* File: verification/sebw_bus_master.sv */
// Two-wire bus master model that drives the serial clock and data line.
`timescale 1ns/1ps
`default_nettype none
module sebw_bus_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_pull
);
  // ==========
  // Bit timing: 8 system clocks a bit, clock stands high outside frames.
  initial begin
    o_scl  = 1'b1;
    o_pull = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Data moves one clock after the clock falls, well clear of its high phase.
  task automatic wbit(input logic b);
    tk(1);
    o_pull <= ~b;
    tk(4);
    o_scl <= 1'b1;
    tk(3);
    o_scl <= 1'b0;
  endtask

  task automatic rbit(output logic b);
    tk(1);
    o_pull <= 1'b0;
    tk(4);
    o_scl <= 1'b1;
    tk(2);
    b = i_sda;
    tk(1);
    o_scl <= 1'b0;
  endtask

  task automatic start();
    tk(1);
    o_pull <= 1'b0;
    tk(4);
    o_scl <= 1'b1;
    tk(4);
    o_pull <= 1'b1;
    tk(4);
    o_scl <= 1'b0;
  endtask

  task automatic stop();
    tk(1);
    o_pull <= 1'b1;
    tk(4);
    o_scl <= 1'b1;
    tk(4);
    o_pull <= 1'b0;
    tk(4);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(ack);
    ack = ~ack;
  endtask

  // The last byte of a read is answered with a released line.
  task automatic rbyte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(~more);
  endtask
endmodule // sebw_bus_master
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the serial memory bus write slave.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int         WC   = 500;
  localparam logic [3:0] CODE = 4'hC; // Arbitrary value.
  logic        clk, resetn, pull, scl, wp, oe, sdo, re, we, busy, csh, csl;
  logic [16:0] addr;
  logic [7:0]  wd, rd;
  logic [7:0]  mem   [0:131071];
  logic [7:0]  ref_m [0:131071];
  int          n_errors, tests_run, n_we, n_busy;
  // The data line has a pull-up; either party may pull it low.
  wire logic   sda = (pull || (oe && !sdo)) ? 1'b0 : 1'b1;

  sebw_bus_master u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
  sebw_slave #(.WC_CYCLES(WC), .DEV_CODE(CODE)) u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda), .o_sda(sdo),
    .o_sda_oe(oe), .i_wp(wp), .i_chip_select_high_pin(csh),
    .i_chip_select_low_pin(csl), .o_arr_re(re), .o_arr_we(we),
    .o_arr_addr(addr), .o_arr_wdata(wd), .i_arr_rdata(rd), .o_busy(busy));

  // ==========
  // Array model: read data follows the strobe by one cycle.
  always @(posedge clk) begin
    if (re) rd <= mem[addr];
    if (we) begin
      mem[addr] <= wd;
      n_we <= n_we + 1;
    end
    if (busy === 1'b1) n_busy <= n_busy + 1;
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========
  // Compare and report.
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: bit got %b want %b", $time, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: byte got %h want %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========
  // Scenarios.
  function automatic logic [7:0] ctl(input logic blk, input logic rw);
    return {CODE, 2'b10, blk, rw};
  endfunction

  task automatic hdr(input logic [16:0] a);
    logic k;
    u_mst.start();
    u_mst.wbyte(ctl(a[16], 1'b0), k);
    chk_bit(k, 1'b1);
    u_mst.wbyte(a[15:8], k);
    chk_bit(k, 1'b1);
    u_mst.wbyte(a[7:0], k);
    chk_bit(k, 1'b1);
  endtask

  task automatic t_mismatch();
    logic k;
    u_mst.start();
    u_mst.wbyte({CODE ^ 4'h1, 4'h8}, k);
    chk_bit(k, 1'b0);
    u_mst.wbyte(8'h00, k);
    chk_bit(k, 1'b0);
    u_mst.start();
    u_mst.wbyte({CODE, 4'h4}, k);
    chk_bit(k, 1'b0);
    u_mst.stop();
    // Swapped select pins must now answer the same byte.
    csh <= 1'b0;
    csl <= 1'b1;
    u_mst.start();
    u_mst.wbyte({CODE, 4'h4}, k);
    chk_bit(k, 1'b1);
    u_mst.stop();
    csh <= 1'b1;
    csl <= 1'b0;
  endtask

  // The protect pin is flipped right after the stop; only its level at the stop counts.
  task automatic finish_write(input logic prot);
    logic k;
    n_we = 0;
    n_busy = 0;
    u_mst.stop();
    chk_bit(busy, !prot);
    wp <= ~wp;
    u_mst.start();
    u_mst.wbyte(ctl(1'b0, 1'b0), k);
    chk_bit(k, prot);
    u_mst.stop();
    for (int t = 0; t < 2000 && busy !== 1'b0; t++) @(posedge clk);
    chk_bit(n_busy == (prot ? 0 : WC), 1'b1);
    chk_bit(n_we == (prot ? 0 : 128), 1'b1);
  endtask

  task automatic pwrite(input logic [16:0] a, input int n, input logic [7:0] s,
                        input logic prot);
    logic        k;
    logic [16:0] p;
    wp <= prot;
    hdr(a);
    for (int i = 0; i < n; i++) begin
      p = {a[16:7], a[6:0] + 7'(i)};
      u_mst.wbyte(s + 8'(i), k);
      chk_bit(k, 1'b1);
      if (!prot) ref_m[p] = s + 8'(i);
    end
    finish_write(prot);
    for (int i = 0; i < 128; i++)
      chk_byte(mem[{a[16:7], 7'(i)}], ref_m[{a[16:7], 7'(i)}]);
  endtask

  task automatic rd_seq(input logic [16:0] a, input int n, input logic set);
    logic       k;
    logic [7:0] d;
    if (set) hdr(a);
    u_mst.start();
    u_mst.wbyte(ctl(a[16], 1'b1), k);
    chk_bit(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(i < n - 1, d);
      chk_byte(d, ref_m[{a[16], a[15:0] + 16'(i)}]);
    end
    u_mst.tk(5);
    chk_bit(oe, 1'b0);
    u_mst.stop();
  endtask

  initial begin
    resetn = 1'b0;
    wp = 1'b0;
    csh = 1'b1;
    csl = 1'b0;
    rd = 8'h00;
    n_errors = 0;
    tests_run = 0;
    for (int i = 0; i < 131072; i++) begin
      // Contents differ between the two blocks so a crossed read shows.
      mem[i] = i[7:0] ^ i[15:8] ^ {i[16], 7'h25};
      ref_m[i] = mem[i];
    end
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_mismatch();
    pwrite(17'h11234, 1, 8'h5A, 1'b0);
    rd_seq(17'h11235, 1, 1'b0);
    pwrite(17'h0017E, 130, 8'h30, 1'b0);
    pwrite(17'h00200, 2, 8'hC3, 1'b1);
    rd_seq(17'h0FFFF, 2, 1'b1);
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
